/* File: pkg/tcsc_pkg.sv */
// package: constants and types of the tach closed-loop speed controller
package tcsc_pkg;
  localparam int          REF_CLK_HZ      = 10_000_000;
  localparam int          TICK_HZ         = 1_000_000;
  localparam int          TICK_DIV        = REF_CLK_HZ / TICK_HZ;
  localparam logic [3:0]  TICK_DIV_LAST   = 4'(TICK_DIV - 1);
  localparam int          LOCK_TIME_MS    = 50;
  localparam logic [15:0] LOCK_TICKS      = 16'(LOCK_TIME_MS * (TICK_HZ / 1000));
  localparam logic [15:0] TARGET_FULL     = 16'h09C4;
  localparam logic [15:0] TARGET_WINDOW   = 16'h0019;
  localparam int          PWM_BITS        = 8;
  localparam logic [7:0]  PWM_PERIOD_LAST = 8'hFF;
  localparam logic [7:0]  DUTY_RESET      = 8'h80;
  localparam logic [7:0]  DUTY_MIN        = 8'h10;
  localparam logic [7:0]  DUTY_MAX        = 8'hF0;
  localparam logic [7:0]  DUTY_STEP       = 8'h01;
  localparam logic [15:0] UPDATE_TICKS    = 16'h03E8;
  localparam int          WINDOW_MS       = 128;
  localparam logic [17:0] WINDOW_TICKS    = 18'(WINDOW_MS * (TICK_HZ / 1000));
  localparam logic [7:0]  WINDOW_TARGET   = 8'h33;
  typedef enum logic [1:0] {SPD_IDLE, SPD_ON, SPD_ADJ, SPD_LOCK} tcsc_speed_e;
endpackage

/* File: rtl/tcsc_pwm_gen.sv */
// file: pwm generator driving the driver speed command input
`timescale 1ns/10ps
module tcsc_pwm_gen
  import tcsc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [7:0] duty,
  output logic            pwmOut
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       pwm;
  } tcsc_pwm_s;
  tcsc_pwm_s st_q, st_d;

  always_comb begin
    st_d     = st_q;
    st_d.cnt = (st_q.cnt == PWM_PERIOD_LAST) ? 8'h00 : st_q.cnt + 8'h01;
    st_d.pwm = (st_q.cnt < duty);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pwmOut = st_q.pwm;
endmodule // tcsc_pwm_gen

/* File: rtl/tcsc_speed_ctrl.sv */
// file: closed-loop speed regulator top
// Notes on behaviour
// - count 1 MHz ticks between tach pulses
// - decide adjustment after every single capture
// - too fast lowers duty, slow raises unlocked
// - duty applied only on update timer event
// - switch low halves target at update event
// - default target 4000 RPM, pressed 2000
// - green lamp when measurement meets target
// - adjusting: red on, green off
// - no pulse for 50 ms flags lock
// - pulse updates status, restarts period and lock timers
// - lock lights both lamps
// - on-target accepted within tolerance window
// - optional pulse count per 128 ms
`timescale 1ns/10ps
module tcsc_speed_ctrl
  import tcsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        speedTachPulseIn,
  input  wire logic        halfSpeedSwitchN,
  output logic             speedTachPulseOut,
  output logic             speedTachPulseOe,
  output logic             speedCommandIn,
  output logic             tachDividerSelect,
  output logic             redAdjustLamp,
  output logic             greenOnTargetLamp,
  output logic             rotorLocked,
  output logic [15:0]      periodTicks,
  output logic [7:0]       windowCount,
  output logic             windowOnTarget
);
  typedef struct packed {
    logic        tachSync;
    logic        tachPrev;
    logic        tachDly;
    logic [3:0]  div;
    logic [15:0] period;
    logic [15:0] captured;
    logic        capValid;
    logic [15:0] lockCnt;
    logic        locked;
    logic [15:0] updCnt;
    logic [15:0] target;
    logic [7:0]  dutyPend;
    logic [7:0]  dutyLive;
    tcsc_speed_e status;
    logic        red;
    logic        green;
    logic [17:0] winTicks;
    logic [7:0]  winPulses;
    logic [7:0]  winCount;
    logic        winOk;
  } tcsc_state_s;
  tcsc_state_s st_q, st_d;

  logic        tick;
  logic        tachFall;
  logic        updEvent;
  logic [15:0] lo;
  logic [15:0] hi;

  function automatic logic [7:0] clampDuty(input logic [8:0] v);
    if (v > {1'b0, DUTY_MAX}) begin
      return DUTY_MAX;
    end else if (v < {1'b0, DUTY_MIN}) begin
      return DUTY_MIN;
    end else begin
      return v[7:0];
    end
  endfunction

  function automatic logic windowEnd(input logic t, input logic [17:0] w);
    return t && (w == WINDOW_TICKS - 18'h00001);
  endfunction

  assign tick     = (st_q.div == TICK_DIV_LAST);
  // edge taken between the second and third stage, never from the first
  assign tachFall = st_q.tachDly & ~st_q.tachPrev;
  assign updEvent = tick && (st_q.updCnt == UPDATE_TICKS - 16'h0001);
  assign lo       = st_q.target - TARGET_WINDOW;
  assign hi       = st_q.target + TARGET_WINDOW;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d          = st_q;
    st_d.tachSync = speedTachPulseIn;
    st_d.tachPrev = st_q.tachSync;
    st_d.tachDly  = st_q.tachPrev;
    st_d.capValid = 1'b0;
    st_d.div      = tick ? 4'h0 : st_q.div + 4'h1;
    if (tick && st_q.period != 16'hFFFF) begin
      st_d.period = st_q.period + 16'h0001;
    end
    if (tick) begin
      st_d.updCnt = updEvent ? 16'h0000 : st_q.updCnt + 16'h0001;
      if (st_q.lockCnt != 16'h0000) begin
        st_d.lockCnt = st_q.lockCnt - 16'h0001;
      end else begin
        st_d.locked = 1'b1;
      end
    end
    if (tachFall) begin
      st_d.captured = st_q.period;
      st_d.capValid = 1'b1;
      st_d.period   = 16'h0000;
      st_d.lockCnt  = LOCK_TICKS;
      st_d.locked   = 1'b0;
    end
    // decision after each capture
    if (st_q.capValid && !st_q.locked) begin
      if (st_q.captured < lo) begin
        st_d.dutyPend = clampDuty({1'b0, st_q.dutyPend} - {1'b0, DUTY_STEP});
        st_d.status   = SPD_ADJ;
      end else if (st_q.captured > hi) begin
        st_d.dutyPend = clampDuty({1'b0, st_q.dutyPend} + {1'b0, DUTY_STEP});
        st_d.status   = SPD_ADJ;
      end else begin
        st_d.status = SPD_ON;
      end
    end
    if (st_q.locked) begin
      st_d.status = SPD_LOCK;
    end
    if (updEvent) begin
      st_d.dutyLive = st_q.dutyPend;
      // pressed switch halves the speed, so the target period doubles
      st_d.target   = halfSpeedSwitchN ? TARGET_FULL : {TARGET_FULL[14:0], 1'b0};
    end
    case (st_q.status)
      SPD_ON: begin
        st_d.red   = 1'b0;
        st_d.green = 1'b1;
      end
      SPD_ADJ: begin
        st_d.red   = 1'b1;
        st_d.green = 1'b0;
      end
      SPD_LOCK: begin
        st_d.red   = 1'b1;
        st_d.green = 1'b1;
      end
      default: begin
        st_d.red   = 1'b0;
        st_d.green = 1'b0;
      end
    endcase
    if (tick) begin
      if (windowEnd(tick, st_q.winTicks)) begin
        st_d.winTicks  = '0;
        st_d.winCount  = st_q.winPulses;
        st_d.winOk     = (st_q.winPulses == WINDOW_TARGET);
        st_d.winPulses = tachFall ? 8'h01 : 8'h00;
      end else begin
        st_d.winTicks = st_q.winTicks + 18'h00001;
      end
    end
    if (tachFall && !windowEnd(tick, st_q.winTicks) && st_q.winPulses != 8'hFF) begin
      st_d.winPulses = st_q.winPulses + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q          <= '0;
      st_q.tachSync <= 1'b1;
      st_q.tachPrev <= 1'b1;
      st_q.tachDly  <= 1'b1;
      st_q.lockCnt  <= LOCK_TICKS;
      st_q.target   <= TARGET_FULL;
      st_q.dutyPend <= DUTY_RESET;
      st_q.dutyLive <= DUTY_RESET;
      st_q.status   <= SPD_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic pwmRaw;
  tcsc_pwm_gen u_pwm (
    .ref_clk (ref_clk),
    .reset   (reset),
    .duty    (st_q.dutyLive),
    .pwmOut  (pwmRaw)
  );

  assign speedCommandIn    = pwmRaw;
  assign speedTachPulseOut = 1'b0;
  assign speedTachPulseOe  = 1'b0;
  assign tachDividerSelect = 1'b0; // full-rate tach
  assign redAdjustLamp     = st_q.red;
  assign greenOnTargetLamp = st_q.green;
  assign rotorLocked       = st_q.locked;
  assign periodTicks       = st_q.captured;
  assign windowCount       = st_q.winCount;
  assign windowOnTarget    = st_q.winOk;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_quiet_window;
    !tachFall [*8];
  endsequence

  sequence s_capture_fast;
    st_q.capValid && !st_q.locked && st_q.captured < lo;
  endsequence

  sequence s_capture_slow;
    st_q.capValid && !st_q.locked && st_q.captured > hi;
  endsequence

  sequence s_capture_in;
    st_q.capValid && !st_q.locked && st_q.captured >= lo && st_q.captured <= hi;
  endsequence

  a_duty_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !updEvent |=> $stable(st_q.dutyLive))
    else $error("duty changed outside update event");

  a_duty_clamp: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.dutyPend >= DUTY_MIN && st_q.dutyPend <= DUTY_MAX)
    else $error("duty outside limits");

  a_capture_restart: assert property (@(posedge ref_clk) disable iff (reset)
    tachFall |=> st_q.period == 16'h0000 && st_q.lockCnt == LOCK_TICKS && st_q.capValid)
    else $error("capture bad");

  a_lock_lamps: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.locked ##1 st_q.locked |=> redAdjustLamp && greenOnTargetLamp)
    else $error("lock lamps off");

  a_lock_timeout: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.lockCnt == 16'h0000 && tick && !tachFall |=> rotorLocked)
    else $error("lock not raised");

  a_adj_lamps: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.status == SPD_ADJ |=> redAdjustLamp && !greenOnTargetLamp)
    else $error("adjust lamps wrong");

  a_on_lamps: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.status == SPD_ON |=> !redAdjustLamp && greenOnTargetLamp)
    else $error("target lamps wrong");

  a_slow_raise: assert property (@(posedge ref_clk) disable iff (reset)
    s_capture_slow and st_q.dutyPend < DUTY_MAX |=> st_q.dutyPend == $past(st_q.dutyPend) + DUTY_STEP)
    else $error("slow not raised");

  a_fast_lower: assert property (@(posedge ref_clk) disable iff (reset)
    s_capture_fast and st_q.dutyPend > DUTY_MIN |=> st_q.dutyPend == $past(st_q.dutyPend) - DUTY_STEP)
    else $error("fast not lowered");

  a_quiet_count: assert property (@(posedge ref_clk) disable iff (reset)
    s_quiet_window |-> st_q.period >= $past(st_q.period, 7))
    else $error("period went back");

  a_slow_adjust: assert property (@(posedge ref_clk) disable iff (reset)
    s_capture_slow |=> st_q.status == SPD_ADJ)
    else $error("slow capture not acted on");

  a_fast_adjust: assert property (@(posedge ref_clk) disable iff (reset)
    s_capture_fast |=> st_q.status == SPD_ADJ)
    else $error("fast capture not acted on");

  a_in_window: assert property (@(posedge ref_clk) disable iff (reset)
    s_capture_in |=> st_q.status == SPD_ON && $stable(st_q.dutyPend))
    else $error("in window capture not on target");

  a_lock_duty_frozen: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.capValid && st_q.locked |=> $stable(st_q.dutyPend))
    else $error("duty moved while locked");

  a_lock_status: assert property (@(posedge ref_clk) disable iff (reset)
    st_q.locked |=> st_q.status == SPD_LOCK)
    else $error("lock status missing");

  a_target_full: assert property (@(posedge ref_clk) disable iff (reset)
    updEvent && halfSpeedSwitchN |=> st_q.target == TARGET_FULL)
    else $error("full target not taken");

  a_target_half: assert property (@(posedge ref_clk) disable iff (reset)
    updEvent && !halfSpeedSwitchN |=> st_q.target == 16'h1388)
    else $error("half speed target not taken");

  a_target_hold: assert property (@(posedge ref_clk) disable iff (reset)
    !updEvent |=> $stable(st_q.target))
    else $error("target changed outside update event");

  a_pulse_unlock: assert property (@(posedge ref_clk) disable iff (reset)
    tachFall |=> !rotorLocked)
    else $error("pulse did not clear lock");

  a_period_count: assert property (@(posedge ref_clk) disable iff (reset)
    tick && !tachFall && st_q.period != 16'hFFFF |=> st_q.period == $past(st_q.period) + 16'h0001)
    else $error("period tick missed");

  a_window_load: assert property (@(posedge ref_clk) disable iff (reset)
    windowEnd(tick, st_q.winTicks) |=> windowCount == $past(st_q.winPulses))
    else $error("window count not loaded");

  a_reset_state: assert property (@(posedge ref_clk)
    reset |=> !redAdjustLamp && !greenOnTargetLamp && !rotorLocked && st_q.dutyLive == DUTY_RESET)
    else $error("reset state wrong");
endmodule // tcsc_speed_ctrl

/* File: dv/tcsc_motor_model.sv */
// file: behavioural fan driver model with open-drain tach output and pwm duty meter
`timescale 1ns/10ps
module tcsc_motor_model (
  input  wire logic        ref_clk,
  input  wire logic        speed_command_in,
  input  wire logic        divSel,
  input  wire logic        run,
  input  wire logic [15:0] periodClks,
  output logic             pullLow,
  output logic [7:0]       dutySeen
);
  logic [16:0] cnt;
  logic [16:0] span;
  logic [7:0]  win;
  logic [7:0]  hi;

  initial begin
    cnt      = '0;
    win      = '0;
    hi       = '0;
    pullLow  = 1'b0;
    dutySeen = '0;
  end

  // divider select high halves the tach rate
  assign span = divSel ? {periodClks, 1'b0} : {1'b0, periodClks};

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    win <= win + 8'h01;
    // duty meter over exactly 256 samples; tach period is set by periodClks, not by this duty
    hi  <= (win == 8'hFF) ? 8'h00 : hi + 8'(speed_command_in);
    if (win == 8'hFF) begin
      dutySeen <= hi + 8'(speed_command_in);
    end
    // locked rotor: line released, pull-up holds it high
    if (!run) begin
      cnt     <= '0;
      pullLow <= 1'b0;
    end else begin
      cnt     <= (cnt >= span - 17'h00001) ? '0 : cnt + 17'h00001;
      pullLow <= (cnt < 17'h0000A);
    end
  end
endmodule // tcsc_motor_model

/* File: dv/tb_top.sv */
// file: self-checking bench of the tach closed-loop speed controller
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_top
  import tcsc_pkg::*;
;
  logic        ref_clk;
  logic        reset;
  logic        tachLine;
  logic        halfSpeedSwitchN;
  logic        tachOut;
  logic        tachOe;
  logic        pwm;
  logic        divSel;
  logic        redLamp;
  logic        greenLamp;
  logic        locked;
  logic [15:0] periodTicks;
  logic        run;
  logic [15:0] periodClks;
  logic        pullLow;
  logic [7:0]  dutySeen;
  logic [7:0]  winCnt;
  logic        winOk;
  int          fails;
  int          testsRun;

  assign tachLine = !(pullLow || (tachOe && !tachOut));

  tcsc_speed_ctrl i_dut (.ref_clk(ref_clk), .reset(reset), .speedTachPulseIn(tachLine),
    .halfSpeedSwitchN(halfSpeedSwitchN), .speedTachPulseOut(tachOut), .speedTachPulseOe(tachOe),
    .speedCommandIn(pwm), .tachDividerSelect(divSel), .redAdjustLamp(redLamp),
    .greenOnTargetLamp(greenLamp), .rotorLocked(locked), .periodTicks(periodTicks),
    .windowCount(winCnt), .windowOnTarget(winOk));

  tcsc_motor_model i_motor (.ref_clk(ref_clk), .speed_command_in(pwm), .divSel(divSel), .run(run),
    .periodClks(periodClks), .pullLow(pullLow), .dutySeen(dutySeen));

  always #50 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (fails == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // wait for a tach fall, then let capture and decision settle
  task automatic wait_fall();
    @(posedge pullLow);
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic t_reset();
    @(negedge ref_clk);
    `CHK("red", 1'b0, redLamp)
    `CHK("tachout", 1'b0, tachOut)
    `CHK("wincnt", 8'h00, winCnt)
    `CHK("winok", 1'b0, winOk)
    `CHK("green", 1'b0, greenLamp)
    `CHK("locked", 1'b0, locked)
    `CHK("divsel", 1'b0, divSel)
    `CHK("tachoe", 1'b0, tachOe)
    repeat (600) @(posedge ref_clk);
    `CHK("duty", DUTY_RESET, dutySeen)
  endtask

  task automatic t_fast();
    @(posedge ref_clk);
    run <= 1'b1;
    repeat (15) wait_fall();
    `CHK("period", 1'b1, (periodTicks >= 16'h0063 && periodTicks <= 16'h0065))
    `CHK("red", 1'b1, redLamp)
    `CHK("green", 1'b0, greenLamp)
    `CHK("locked", 1'b0, locked)
    repeat (600) @(posedge ref_clk);
    `CHK("dutydown", 1'b1, (dutySeen < DUTY_RESET))
    `CHK("dutymin", 1'b1, (dutySeen >= DUTY_MIN))
  endtask

  // period near the upper edge of the tolerance window around full target
  task automatic t_target();
    @(posedge ref_clk);
    periodClks <= 16'h6270;
    wait_fall();
    `CHK("period", 1'b1, (periodTicks >= 16'h09D7 && periodTicks <= 16'h09D9))
    `CHK("green", 1'b1, greenLamp)
    `CHK("red", 1'b0, redLamp)
  endtask

  // pressed switch doubles the target period, so same speed is too fast
  task automatic t_half();
    @(posedge ref_clk);
    halfSpeedSwitchN <= 1'b0;
    wait_fall();
    `CHK("red", 1'b1, redLamp)
    `CHK("green", 1'b0, greenLamp)
    @(posedge ref_clk);
    halfSpeedSwitchN <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk          = 1'b0;
    reset            = 1'b1;
    halfSpeedSwitchN = 1'b1;
    run              = 1'b0;
    periodClks       = 16'h03E8;
    fails            = 0;
    testsRun         = 0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_fast();
    t_target();
    t_half();
    results();
  end

  initial begin
    #9_000_000;
    fails++;
    results();
  end
endmodule // tb_top
